// ---- sdram_seq_pkg.sv ----
package sdram_seq_pkg;
    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS    = 100;
    localparam int STABLE_US        = 200;
    localparam int STABLE_CYC       = (STABLE_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int ROW_ACTIVE_NS    = 42;
    localparam int ROW_ACTIVE_CYC   = (ROW_ACTIVE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SETUP_NS         = 2;
    localparam int ROW_CYCLE_NS     = 63;
    localparam int EXIT_NS          = SETUP_NS + ROW_CYCLE_NS;
    localparam int EXIT_CYC         = (EXIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int PRECHARGE_NS     = 21;
    localparam int PRECHARGE_CYC    = (PRECHARGE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int MODE_SET_CYC     = 2;
    localparam int INIT_REFRESHES   = 2;
    localparam int BURST_REFRESHES  = 4096;
    localparam int CNT_W            = 12;
    // ------------------------------------------------------------
    // command codes {cs_n, ras_n, cas_n, we_n} and address values
    // ------------------------------------------------------------
    localparam logic [3:0] CMD_NO_OPERATION = 4'h7;
    localparam logic [3:0] CMD_DESELECT     = 4'hf;
    localparam logic [3:0] CMD_PRECHARGE    = 4'h2;
    localparam logic [3:0] CMD_MODE_SET     = 4'h0;
    localparam logic [3:0] CMD_REFRESH      = 4'h1;
    localparam logic [10:0] ADDR_ALL_BANKS  = 11'h400;
    localparam logic [10:0] MODE_DEFAULT    = 11'h020;
endpackage : sdram_seq_pkg

// ---- sdram_init_self_refresh_seq.sv ----
`timescale 1ns/1ps
// Function
// - power-up: cke low, mask high, no_operation
// - stable clock 200 us before cke high
// - keep byte mask high during init
// - precharge all banks after cke high
// - issue mode register set during init
// - at least two auto refreshes in init
// - cs ras cas low with cke low
// - device ignores inputs after entry cycle
// - hold self refresh at least row active time
// - restart clock then raise cke with setup
// - chip select high when cke rises
// - wait exit time before real commands
// - burst refresh 4096 before entry, after exit
// - row active time 42 ns minimum
// - exit time is setup plus row cycle
// - row cycle 60 or 63 ns
module sdram_init_self_refresh_seq (
    input  wire logic        sys_clk,
    input  wire logic        reset,
    input  wire logic        clk_en,
    input  wire logic        sr_enter,
    input  wire logic        sr_exit,
    input  wire logic        burst_mode,
    output logic             mem_clk_run,
    output logic             clock_enable,
    output logic             chip_select_n,
    output logic             row_strobe_n,
    output logic             column_strobe_n,
    output logic             write_strobe_n,
    output logic [1:0]       byte_mask,
    output logic [10:0]      mem_addr,
    output logic             ready,
    output logic             in_self_refresh
);
    // ------------------------------------------------------------
    // states
    // ------------------------------------------------------------
    typedef enum logic [9:0] {
        S_STABLE  = 10'h001,
        S_PRECH   = 10'h002,
        S_MODE    = 10'h004,
        S_REF     = 10'h008,
        S_IDLE    = 10'h010,
        S_PRE_BR  = 10'h020,
        S_SELF    = 10'h040,
        S_WAKE    = 10'h080,
        S_EXIT    = 10'h100,
        S_POST_BR = 10'h200
    } state_t;

    localparam int CNT_W = sdram_seq_pkg::CNT_W;

    state_t           state_r;
    state_t           state_nxt;
    logic [17:0]      wait_r;
    logic [17:0]      wait_nxt;
    logic [CNT_W:0]   ref_r;
    logic [CNT_W:0]   ref_nxt;
    logic [3:0]       cmd_nxt;
    logic             cke_nxt;
    logic [10:0]      addr_nxt;
    logic [1:0]       enter_sync_r;
    logic [1:0]       exit_sync_r;
    logic [1:0]       burst_sync_r;

    wire waited   = (wait_r == 18'h0);
    wire enter_rq = enter_sync_r[1];
    wire exit_rq  = exit_sync_r[1];
    wire burst_on = burst_sync_r[1];
    wire ref_done = (ref_r == 13'h0);

    // ------------------------------------------------------------
    // output next values
    // ------------------------------------------------------------
    wire       idle_nxt    = (state_nxt == S_IDLE);
    wire       self_nxt    = (state_nxt == S_SELF);
    wire       clk_run_nxt = !self_nxt || (state_r != S_SELF);
    wire [1:0] mask_nxt    = idle_nxt ? 2'h0 : 2'h3;

    function automatic logic [17:0] cyc(input int n);
        cyc = 18'(n);
    endfunction : cyc

    // ------------------------------------------------------------
    // sequencing
    // ------------------------------------------------------------
    always_comb begin
        state_nxt = state_r;
        wait_nxt  = waited ? wait_r : wait_r - 18'h1;
        ref_nxt   = ref_r;
        cmd_nxt   = sdram_seq_pkg::CMD_NO_OPERATION;
        cke_nxt   = 1'b1;
        addr_nxt  = 11'h000;
        unique case (state_r)
            S_STABLE: begin
                cke_nxt = 1'b0;
                if (waited) begin
                    cke_nxt   = 1'b1;
                    state_nxt = S_PRECH;
                    wait_nxt  = cyc(1);
                end
            end
            S_PRECH: if (waited) begin
                cmd_nxt   = sdram_seq_pkg::CMD_PRECHARGE;
                addr_nxt  = sdram_seq_pkg::ADDR_ALL_BANKS;
                state_nxt = S_MODE;
                wait_nxt  = cyc(sdram_seq_pkg::PRECHARGE_CYC);
            end
            S_MODE: if (waited) begin
                cmd_nxt   = sdram_seq_pkg::CMD_MODE_SET;
                addr_nxt  = sdram_seq_pkg::MODE_DEFAULT;
                state_nxt = S_REF;
                wait_nxt  = cyc(sdram_seq_pkg::MODE_SET_CYC);
                ref_nxt   = 13'(sdram_seq_pkg::INIT_REFRESHES);
            end
            S_REF: if (waited) begin
                if (ref_done) begin
                    state_nxt = S_IDLE;
                end else begin
                    cmd_nxt  = sdram_seq_pkg::CMD_REFRESH;
                    ref_nxt  = ref_r - 13'h1;
                    wait_nxt = cyc(sdram_seq_pkg::EXIT_CYC);
                end
            end
            S_IDLE: if (enter_rq) begin
                state_nxt = S_PRE_BR;
                ref_nxt   = burst_on ? 13'(sdram_seq_pkg::BURST_REFRESHES) : 13'h0;
            end
            S_PRE_BR: if (waited) begin
                if (ref_done) begin
                    cmd_nxt   = sdram_seq_pkg::CMD_REFRESH;
                    cke_nxt   = 1'b0;
                    state_nxt = S_SELF;
                    wait_nxt  = cyc(sdram_seq_pkg::ROW_ACTIVE_CYC);
                end else begin
                    cmd_nxt  = sdram_seq_pkg::CMD_REFRESH;
                    ref_nxt  = ref_r - 13'h1;
                    wait_nxt = cyc(sdram_seq_pkg::EXIT_CYC);
                end
            end
            S_SELF: begin
                cke_nxt = 1'b0;
                cmd_nxt = sdram_seq_pkg::CMD_DESELECT;
                if (waited && exit_rq) begin
                    state_nxt = S_WAKE;
                end
            end
            S_WAKE: begin
                cke_nxt   = 1'b1;
                cmd_nxt   = sdram_seq_pkg::CMD_DESELECT;
                state_nxt = S_EXIT;
                wait_nxt  = cyc(sdram_seq_pkg::EXIT_CYC);
            end
            S_EXIT: begin
                cmd_nxt = sdram_seq_pkg::CMD_DESELECT;
                if (waited) begin
                    state_nxt = S_POST_BR;
                    ref_nxt   = burst_on ? 13'(sdram_seq_pkg::BURST_REFRESHES) : 13'h0;
                end
            end
            S_POST_BR: if (waited) begin
                if (ref_done) begin
                    state_nxt = S_IDLE;
                end else begin
                    cmd_nxt  = sdram_seq_pkg::CMD_REFRESH;
                    ref_nxt  = ref_r - 13'h1;
                    wait_nxt = cyc(sdram_seq_pkg::EXIT_CYC);
                end
            end
            default: state_nxt = S_STABLE;
        endcase
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            state_r <= S_STABLE;
            wait_r  <= 18'(sdram_seq_pkg::STABLE_CYC);
            ref_r   <= 13'h0;
        end else if (clk_en) begin
            state_r <= state_nxt;
            wait_r  <= wait_nxt;
            ref_r   <= ref_nxt;
        end
    end

    // ------------------------------------------------------------
    // request synchronisers
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            enter_sync_r <= 2'h0;
            exit_sync_r  <= 2'h0;
            burst_sync_r <= 2'h0;
        end else if (clk_en) begin
            enter_sync_r <= {enter_sync_r[0], sr_enter};
            exit_sync_r  <= {exit_sync_r[0], sr_exit};
            burst_sync_r <= {burst_sync_r[0], burst_mode};
        end
    end

    // ------------------------------------------------------------
    // pin registers
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            clock_enable    <= 1'b0;
            {chip_select_n, row_strobe_n, column_strobe_n, write_strobe_n} <= sdram_seq_pkg::CMD_NO_OPERATION;
            mem_addr        <= 11'h000;
            byte_mask       <= 2'h3;
            mem_clk_run     <= 1'b0;
            ready           <= 1'b0;
            in_self_refresh <= 1'b0;
        end else if (clk_en) begin
            clock_enable    <= cke_nxt;
            {chip_select_n, row_strobe_n, column_strobe_n, write_strobe_n} <= cmd_nxt;
            mem_addr        <= addr_nxt;
            byte_mask       <= mask_nxt;
            mem_clk_run     <= clk_run_nxt;
            ready           <= idle_nxt;
            in_self_refresh <= self_nxt;
        end
    end
endmodule : sdram_init_self_refresh_seq

// ---- sdram_seq_props.sv ----
`timescale 1ns/1ps
module sdram_seq_props (
    input wire logic        sys_clk,
    input wire logic        reset,
    input wire logic        clock_enable,
    input wire logic        chip_select_n,
    input wire logic        row_strobe_n,
    input wire logic        column_strobe_n,
    input wire logic        write_strobe_n,
    input wire logic [1:0]  byte_mask,
    input wire logic [10:0] mem_addr,
    input wire logic        mem_clk_run,
    input wire logic        ready,
    input wire logic        in_self_refresh
);
    // ----------------------------------------
    // counters and command checks
    // ----------------------------------------
    logic [10:0] up_r;
    logic [1:0]  ref_r;
    logic [3:0]  cmd;
    assign cmd = {chip_select_n, row_strobe_n, column_strobe_n, write_strobe_n};
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            up_r  <= 11'h0;
            ref_r <= 2'h0;
        end else begin
            if (up_r != 11'h7ff) up_r <= up_r + 11'h1;
            if (cmd == 4'h1 && clock_enable && ref_r != 2'h3) ref_r <= ref_r + 2'h1;
        end
    end
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (reset);
    a_cke_settle: assert property ($rose(clock_enable) |-> up_r >= 11'(sdram_seq_pkg::STABLE_CYC))
        else $error("cke rose early");
    a_mask_high: assert property (!ready |-> byte_mask == 2'h3)
        else $error("mask low");
    a_prech_all: assert property (cmd == 4'h2 |-> mem_addr == sdram_seq_pkg::ADDR_ALL_BANKS)
        else $error("precharge not all banks");
    a_gap_nop: assert property (cmd inside {4'h0, 4'h2} |=> cmd inside {4'h7, 4'hf})
        else $error("no gap after command");
    a_init_refr: assert property ($rose(ready) |-> ref_r >= 2'h2)
        else $error("too few refreshes");
    a_sr_entry: assert property ($rose(in_self_refresh) |-> cmd == 4'h1 && !clock_enable)
        else $error("bad entry command");
    a_sr_hold: assert property ($rose(in_self_refresh) |=> !clock_enable && !mem_clk_run)
        else $error("self refresh not held");
    a_exit_cs: assert property ($rose(clock_enable) && up_r == 11'h7ff |-> cmd == 4'hf && mem_clk_run && $past(mem_clk_run) ##1 cmd inside {4'h7, 4'hf})
        else $error("bad exit");
endmodule : sdram_seq_props
bind sdram_init_self_refresh_seq sdram_seq_props u_props (.sys_clk, .reset, .clock_enable, .chip_select_n,
    .row_strobe_n, .column_strobe_n, .write_strobe_n, .byte_mask, .mem_addr, .mem_clk_run, .ready, .in_self_refresh);

// ---- sdram_device_model.sv ----
`timescale 1ns/1ps
module sdram_device_model (
    input  wire logic        sys_clk,
    input  wire logic        mem_clk_run,
    input  wire logic        clock_enable,
    input  wire logic [3:0]  cmd,
    input  wire logic [10:0] mem_addr,
    output logic             sr,
    output logic             init_ok,
    output int               refs
);
    logic pre_r  = 1'b0;
    logic mode_r = 1'b0;
    logic cke_r  = 1'b0;
    logic sr_r   = 1'b0;
    int   refs_r = 0;
    assign sr      = sr_r;
    assign refs    = refs_r;
    assign init_ok = pre_r && mode_r && refs_r >= 2;
    always @(posedge sys_clk) begin
        cke_r <= clock_enable;
        if (sr_r) begin
            if (clock_enable) sr_r <= 1'b0;
        end else if (mem_clk_run && clock_enable) begin
            if (cmd == 4'h2 && mem_addr[10]) pre_r <= 1'b1;
            if (cmd == 4'h0) mode_r <= 1'b1;
            if (cmd == 4'h1) refs_r <= refs_r + 1;
        end else if (mem_clk_run && cke_r && cmd == 4'h1) sr_r <= 1'b1;
    end
endmodule : sdram_device_model

// ---- sdram_init_self_refresh_seq_tb.sv ----
`timescale 1ns/1ps
module sdram_init_self_refresh_seq_tb;
    logic        sys_clk = 0, reset = 1, clk_en = 1, sr_enter = 0, sr_exit = 0, burst_mode = 0;
    logic        mem_clk_run, clock_enable, chip_select_n, row_strobe_n, column_strobe_n, write_strobe_n;
    logic        ready, in_self_refresh, sr, init_ok;
    logic [1:0]  byte_mask;
    logic [10:0] mem_addr;
    int          refs, r0, i, n_fail = 0, cmp_count = 0;
    always #50 sys_clk = ~sys_clk;
    sdram_init_self_refresh_seq dut (.sys_clk, .reset, .clk_en, .sr_enter, .sr_exit, .burst_mode, .mem_clk_run,
        .clock_enable, .chip_select_n, .row_strobe_n, .column_strobe_n, .write_strobe_n, .byte_mask, .mem_addr,
        .ready, .in_self_refresh);
    sdram_device_model model (.sys_clk, .mem_clk_run, .clock_enable, .mem_addr, .sr, .init_ok, .refs,
        .cmd({chip_select_n, row_strobe_n, column_strobe_n, write_strobe_n}));
    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            n_fail++;
            $display("CHECK FAILED %s exp %0h got %0h", nm, e, g);
        end
    endtask : chk
    task tick(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask : tick
    task end_of_test;
        $display("compares %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : end_of_test
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task t_init;
        chk("mask_up", 3, byte_mask);
        for (i = 0; i < 3000 && clock_enable !== 1'b1; i++) tick(1);
        chk("cke_wait", 1, i >= sdram_seq_pkg::STABLE_CYC);
        for (i = 0; i < 100 && ready !== 1'b1; i++) tick(1);
        chk("init_ready", 1, ready);
        chk("init_ok", 1, init_ok);
    endtask : t_init
    task t_mid_reset;
        tick(500);
        reset = 1;
        tick(2);
        chk("reset_pins", 8'h37, {clock_enable, byte_mask, chip_select_n, row_strobe_n, column_strobe_n, write_strobe_n});
        reset = 0;
        t_init();
    endtask : t_mid_reset
    task t_freeze_refuse;
        clk_en = 0;
        sr_enter = 1;
        tick(30);
        chk("frozen", 0, in_self_refresh);
        clk_en = 1;
        sr_enter = 0;
        sr_exit = 1;
        tick(10);
        chk("refused", 2, {ready, in_self_refresh});
        sr_exit = 0;
        tick(4);
    endtask : t_freeze_refuse
    task t_sr(input logic b);
        burst_mode = b;
        r0 = refs;
        sr_enter = 1;
        for (i = 0; i < 9000 && in_self_refresh !== 1'b1; i++) tick(1);
        sr_enter = 0;
        chk("pre_refs", b ? 4096 : 0, refs - r0);
        tick(3);
        chk("sr_state", 3'h4, {sr, clock_enable, mem_clk_run});
        r0 = refs;
        sr_exit = 1;
        for (i = 0; i < 9000 && ready !== 1'b1; i++) tick(1);
        sr_exit = 0;
        chk("post_refs", b ? 4096 : 0, refs - r0);
        chk("sr_left", 0, {sr, in_self_refresh});
    endtask : t_sr
    initial begin
        tick(16);
        reset = 0;
        t_init();
        t_mid_reset();
        t_freeze_refuse();
        t_sr(1'b0);
        t_sr(1'b1);
        end_of_test();
    end
    initial begin
        #4000000;
        n_fail++;
        end_of_test();
    end
endmodule : sdram_init_self_refresh_seq_tb
